// ===== dv/selftest_irq_bank_tb.sv
// self-checking bench for the self-test and fault interrupt enable bank
module selftest_irq_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         WAIT_CYC = 10;
	localparam logic [35:0] OTP_PAT = 36'h9a5c36f21;
	logic        ref_clk_i = 1'h0;
	logic        resetn_i = 1'h0;
	logic        reg_wr_i = 1'h0;
	logic        reg_rd_i = 1'h0;
	logic [7:0]  reg_addr_i = 8'h00;
	logic [7:0]  reg_wdata_i = 8'h00;
	logic [7:0]  reg_rdata_o;
	logic        cfg_lock_i = 1'h0;
	logic        prot_i = 1'h0;
	logic        otp_reload_i = 1'h0;
	logic [1:0]  otp_sel_i = 2'h1;
	logic [35:0] otp_ien_i = OTP_PAT;
	logic [35:0] flags_i = 36'h000000000;
	logic        force_i = 1'h0;
	logic        act_i = 1'h1;
	logic        irq_n_o;
	logic        run_o;
	logic        corrupt_o;
	logic        ready_o;
	int          miscompares = 0;
	int          tests_run = 0;
	int          cycles = 0;
	int          g;
	int          n;
	// the bank under test, wait time cut to WAIT_CYC cycles
	selftest_irq_bank #(.CFG_WAIT_NS(WAIT_CYC * 10)) i_dut (.REF_CLK_I(ref_clk_i),
		.RESETN_I(resetn_i), .REG_WR_I(reg_wr_i), .REG_RD_I(reg_rd_i),
		.REG_ADDR_I(reg_addr_i), .REG_WDATA_I(reg_wdata_i), .REG_RDATA_O(reg_rdata_o),
		.CFG_LOCK_I(cfg_lock_i), .IRQ_ENABLE_PROTECT_GROUP_I(prot_i),
		.OTP_RELOAD_I(otp_reload_i), .OTP_SELTEST_SEL_I(otp_sel_i), .OTP_IEN_I(otp_ien_i),
		.FAULT_FLAGS_I(flags_i), .FORCE_INTERRUPT_OUT_I(force_i),
		.ACTIVITY_INPUT_I(act_i), .INTERRUPT_OUT_N_O(irq_n_o), .SELFTEST_RUN_O(run_o),
		.SELFTEST_CORRUPT_O(corrupt_o), .READY_O(ready_o));
	// 100 MHz clock
	initial
	begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	task automatic report_and_stop();
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard, well above the few hundred cycles the tests need
	always @(posedge ref_clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares = miscompares + 1;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// settle just after the k-th following edge
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'h0;
	endtask
	// data stands just after the taking edge and is checked one edge later
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'h0;
		tick(1);
		chk("read data", exp, reg_rdata_o);
	endtask
	// count start pulses over a window, then check ready and corrupt levels
	task automatic watch(input int pulses, input logic corrupt);
		n = 0;
		repeat (WAIT_CYC + 4)
		begin
			tick(1);
			if (run_o === 1'h1)
				n = n + 1;
		end
		chk("run pulses", 8'(pulses), 8'(n));
		chk("ready", 8'h01, {7'h00, ready_o});
		chk("corrupt", {7'h00, corrupt}, {7'h00, corrupt_o});
	endtask
	// main sequence
	initial
	begin
		repeat (4) @(posedge ref_clk_i);
		resetn_i <= 1'h1;
		watch(1, 1'h1);
		rd(8'h12, 8'h01);
		for (g = 0; g < 6; g++)
			rd(8'h13 + 8'(g), {2'h0, OTP_PAT[6*g +: 6]});
		rd(8'h19, 8'h00);
		// all enables written, then read back, reserved bits read zero
		for (g = 0; g < 6; g++)
			wr(8'h13 + 8'(g), 8'hff ^ (8'h01 << g));
		for (g = 0; g < 6; g++)
			rd(8'h13 + 8'(g), 8'h3f & (8'hff ^ (8'h01 << g)));
		wr(8'h12, 8'hfe);
		rd(8'h12, 8'h06);
		cfg_lock_i <= 1'h1;
		prot_i <= 1'h1;
		wr(8'h12, 8'h01);
		wr(8'h15, 8'h3f);
		rd(8'h12, 8'h06);
		rd(8'h15, 8'h3b);
		cfg_lock_i <= 1'h0;
		prot_i <= 1'h0;
		// each group gates only its own flags, channel x on bit x-1
		for (g = 0; g < 6; g++)
			wr(8'h13 + 8'(g), 8'h00);
		for (g = 0; g < 6; g++)
		begin
			wr(8'h13 + 8'(g), 8'h01 << g);
			flags_i <= 36'h1 << (6 * ((g + 1) % 6) + g);
			tick(2);
			chk("irq other group", 8'h01, {7'h00, irq_n_o});
			flags_i <= 36'h1 << (6 * g + g);
			tick(2);
			chk("irq enabled", 8'h00, {7'h00, irq_n_o});
			wr(8'h13 + 8'(g), 8'h00);
			tick(2);
			chk("irq disabled", 8'h01, {7'h00, irq_n_o});
			force_i <= 1'h1;
			tick(2);
			chk("irq forced", 8'h00, {7'h00, irq_n_o});
			force_i <= 1'h0;
			flags_i <= 36'h000000000;
		end
		tick(2);
		chk("irq idle", 8'h01, {7'h00, irq_n_o});
		// shutdown self-test on activity fall, ready after the wait
		wr(8'h12, 8'h07);
		act_i <= 1'h0;
		watch(1, 1'h1);
		act_i <= 1'h1;
		wr(8'h12, 8'h03);
		tick(4);
		act_i <= 1'h0;
		watch(0, 1'h1);
		act_i <= 1'h1;
		// every power-on code through a reload, shutdown bit set beforehand
		for (g = 0; g < 4; g++)
		begin
			wr(8'h12, 8'h04);
			otp_sel_i <= 2'(g);
			@(posedge ref_clk_i);
			otp_reload_i <= 1'h1;
			@(posedge ref_clk_i);
			otp_reload_i <= 1'h0;
			watch(g != 0, g == 1 || g == 2);
			rd(8'h12, 8'(g));
		end
		report_and_stop();
	end
endmodule // selftest_irq_bank_tb

// ===== hdl/level_sync.sv
// two flip-flop synchroniser for levels arriving from outside the clock domain
module level_sync #(
	parameter int W = 1
) (
	input  wire logic         REF_CLK_I,
	input  wire logic         RESETN_I,
	input  wire logic [W-1:0] D_I,
	output logic      [W-1:0] Q_O
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;

	sync_t st_r;
	sync_t st_nxt;

	initial
	begin
		if (W < 1) $error("level_sync width must be at least one");
	end

	// first stage feeds only the second stage
	always_comb
	begin
		st_nxt    = st_r;
		st_nxt.s1 = D_I;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (!RESETN_I)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign Q_O = st_r.s2;
endmodule // level_sync

// ===== hdl/selftest_irq_bank.sv
// self-test trigger configuration and per-channel fault interrupt enable registers
// Operation
// - test config register host writable, writes ignored while config group locked
// - reset loads the power-on self-test field and every enable register from otp, shutdown bit zero
// - shutdown bit set: activity fall starts self-test, ready after wait time
// - shutdown self-test bit always comes up zero on an otp load
// - field 00 skips, 01/10 corrupt run, 11 valid run; ready after wait
// - power-on field host writes have no effect while config group locked
// - enable registers writable, writes ignored while enable group locked
// - every enable register loads its contents from otp at power-on
// - bit x-1 enables channel x, bits 7 and 6 reserved zero
// - offset 0x13 gates fast under-voltage fault interrupts
// - offset 0x14 gates slow under-voltage fault interrupts
// - offset 0x15 gates fast over-voltage fault interrupts
// - offset 0x16 gates slow over-voltage fault interrupts
// - offset 0x17 gates power-on sequence fault interrupts
// - offset 0x18 gates power-off sequence fault interrupts
// - clearing an enable leaves fault flags untouched, only gating changes
// - fault flags clear only by host write-one-to-clear
// - active-low interrupt follows enabled faults unless forced asserted
module selftest_irq_bank #(
	parameter int CFG_WAIT_NS = vmon_cfg_pkg::CFG_WAIT_NS
) (
	input  wire logic                                REF_CLK_I,
	input  wire logic                                RESETN_I,
	input  wire logic                                REG_WR_I,
	input  wire logic                                REG_RD_I,
	input  wire logic [vmon_cfg_pkg::ADDR_W-1:0]     REG_ADDR_I,
	input  wire logic [vmon_cfg_pkg::DATA_W-1:0]     REG_WDATA_I,
	output logic      [vmon_cfg_pkg::DATA_W-1:0]     REG_RDATA_O,
	input  wire logic                                CFG_LOCK_I,
	input  wire logic                                IRQ_ENABLE_PROTECT_GROUP_I,
	input  wire logic                                OTP_RELOAD_I,
	input  wire logic [1:0]                          OTP_SELTEST_SEL_I,
	input  wire logic [vmon_cfg_pkg::NUM_IEN*vmon_cfg_pkg::NUM_CH-1:0] OTP_IEN_I,
	input  wire logic [vmon_cfg_pkg::NUM_IEN*vmon_cfg_pkg::NUM_CH-1:0] FAULT_FLAGS_I,
	input  wire logic                                FORCE_INTERRUPT_OUT_I,
	input  wire logic                                ACTIVITY_INPUT_I,
	output logic                                     INTERRUPT_OUT_N_O,
	output logic                                     SELFTEST_RUN_O,
	output logic                                     SELFTEST_CORRUPT_O,
	output logic                                     READY_O
);
	localparam int NCH      = vmon_cfg_pkg::NUM_CH;
	localparam int NIEN     = vmon_cfg_pkg::NUM_IEN;
	localparam int WAIT_CYC = (CFG_WAIT_NS * vmon_cfg_pkg::CLK_MHZ + 999) / 1000;
	localparam logic [vmon_cfg_pkg::CNT_W-1:0] WAIT_LAST =
		vmon_cfg_pkg::CNT_W'(WAIT_CYC - 1);

	vmon_cfg_pkg::bank_t st_r;
	vmon_cfg_pkg::bank_t st_nxt;
	logic                act_s;
	logic [NCH-1:0]      ch_hit;
	logic [NIEN-1:0][NCH-1:0] flags;

	initial
	begin
		if (WAIT_CYC < 1 || WAIT_CYC > 4096)
			$error("config wait time must give 1 to 4096 cycles");
	end

	// activity pin comes from outside the clock domain
	level_sync #(.W(1)) u_act_sync (
		.REF_CLK_I (REF_CLK_I),
		.RESETN_I  (RESETN_I),
		.D_I       (ACTIVITY_INPUT_I),
		.Q_O       (act_s)
	);

	assign flags = FAULT_FLAGS_I;

	// per channel: any fault flag whose enable is set; flags are only read here,
	// so enables never disturb them
	for (genvar ch = 0; ch < NCH; ch++)
	begin : g_ch
		assign ch_hit[ch] = (flags[vmon_cfg_pkg::GRP_FUV][ch]  & st_r.irq_enable_protect_group[vmon_cfg_pkg::GRP_FUV][ch])
		                  | (flags[vmon_cfg_pkg::GRP_SUV][ch]  & st_r.irq_enable_protect_group[vmon_cfg_pkg::GRP_SUV][ch])
		                  | (flags[vmon_cfg_pkg::GRP_FOV][ch]  & st_r.irq_enable_protect_group[vmon_cfg_pkg::GRP_FOV][ch])
		                  | (flags[vmon_cfg_pkg::GRP_SOV][ch]  & st_r.irq_enable_protect_group[vmon_cfg_pkg::GRP_SOV][ch])
		                  | (flags[vmon_cfg_pkg::GRP_SON][ch]  & st_r.irq_enable_protect_group[vmon_cfg_pkg::GRP_SON][ch])
		                  | (flags[vmon_cfg_pkg::GRP_SOFF][ch] & st_r.irq_enable_protect_group[vmon_cfg_pkg::GRP_SOFF][ch]);
	end

	// next-state logic: otp load, host access, interrupt pin and self-test sequencing
	always_comb
	begin
		logic [7:0] grp;
		logic       in_ien;
		grp             = REG_ADDR_I - vmon_cfg_pkg::ADDR_IEN_FUV;
		in_ien          = (REG_ADDR_I >= vmon_cfg_pkg::ADDR_IEN_FUV)
		               && (REG_ADDR_I <= vmon_cfg_pkg::ADDR_IEN_SOFF);
		st_nxt          = st_r;
		st_nxt.run      = 1'b0;
		st_nxt.act_d    = act_s;
		// a reload pulse re-arms the power-on decode for the next cycle;
		// a pulse that lands while a wait is running is not queued
		st_nxt.load_pend = OTP_RELOAD_I;

		// host writes; lock inputs freeze the groups
		if (REG_WR_I && REG_ADDR_I == vmon_cfg_pkg::ADDR_TEST_CFG && !CFG_LOCK_I)
		begin
			st_nxt.sel = REG_WDATA_I[vmon_cfg_pkg::SEL_MSB:vmon_cfg_pkg::SEL_LSB];
			st_nxt.sd  = REG_WDATA_I[vmon_cfg_pkg::SD_BIT];
		end
		if (REG_WR_I && in_ien && !IRQ_ENABLE_PROTECT_GROUP_I)
			st_nxt.irq_enable_protect_group[grp[2:0]] = REG_WDATA_I[NCH-1:0];

		// otp load wins over a host write in the same cycle
		if (st_r.load_pend || OTP_RELOAD_I)
		begin
			st_nxt.sel = OTP_SELTEST_SEL_I;
			st_nxt.sd  = vmon_cfg_pkg::SD_DEFAULT;
			st_nxt.irq_enable_protect_group = OTP_IEN_I;
		end

		// registered read; reserved and unmapped bits read zero
		if (REG_RD_I)
		begin
			st_nxt.rdata = vmon_cfg_pkg::ZERO_BYTE;
			if (REG_ADDR_I == vmon_cfg_pkg::ADDR_TEST_CFG)
			begin
				st_nxt.rdata[vmon_cfg_pkg::SEL_MSB:vmon_cfg_pkg::SEL_LSB] = st_r.sel;
				st_nxt.rdata[vmon_cfg_pkg::SD_BIT] = st_r.sd;
			end
			else if (in_ien)
				st_nxt.rdata[NCH-1:0] = st_r.irq_enable_protect_group[grp[2:0]];
		end

		// pin stays low while any enabled flag is up; flags drop only by
		// the host's write-one-to-clear in the flag registers
		st_nxt.irq_n = !(FORCE_INTERRUPT_OUT_I || (|ch_hit));

		case (st_r.seq)
			vmon_cfg_pkg::ST_IDLE:
			begin
				if (st_r.load_pend)
				begin
					// power-on decode uses the freshly loaded otp field
					st_nxt.run     = (OTP_SELTEST_SEL_I != vmon_cfg_pkg::SEL_SKIP);
					st_nxt.corrupt = (OTP_SELTEST_SEL_I != vmon_cfg_pkg::SEL_SKIP)
					              && (OTP_SELTEST_SEL_I != vmon_cfg_pkg::SEL_RUN_VALID);
					st_nxt.ready   = 1'b0;
					st_nxt.cnt     = WAIT_LAST;
					st_nxt.seq     = vmon_cfg_pkg::ST_WAIT;
				end
				else if (st_r.act_d && !act_s && st_r.sd)
				begin
					st_nxt.run   = 1'b1;
					st_nxt.ready = 1'b0;
					st_nxt.cnt   = WAIT_LAST;
					st_nxt.seq   = vmon_cfg_pkg::ST_WAIT;
				end
			end
			vmon_cfg_pkg::ST_WAIT:
			begin
				// deactivation edges during the wait are not queued
				if (st_r.cnt == '0)
				begin
					st_nxt.ready = 1'b1;
					st_nxt.seq   = vmon_cfg_pkg::ST_IDLE;
				end
				else
					st_nxt.cnt = st_r.cnt - 1'b1;
			end
			default:
				st_nxt.seq = vmon_cfg_pkg::ST_IDLE;
		endcase
	end

	// state register; reset leaves load pending so otp comes in on release
	always_ff @(posedge REF_CLK_I)
	begin
		if (!RESETN_I)
		begin
			st_r           <= '0;
			st_r.irq_n     <= 1'b1;
			st_r.load_pend <= 1'b1;
			st_r.seq       <= vmon_cfg_pkg::ST_IDLE;
		end
		else
			st_r <= st_nxt;
	end

	assign REG_RDATA_O        = st_r.rdata;
	assign INTERRUPT_OUT_N_O  = st_r.irq_n;
	assign SELFTEST_RUN_O     = st_r.run;
	assign SELFTEST_CORRUPT_O = st_r.corrupt;
	assign READY_O            = st_r.ready;

	// checks
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RESETN_I);

	chk_cfg_lock_hold: assert property (
		(REG_WR_I && REG_ADDR_I == vmon_cfg_pkg::ADDR_TEST_CFG && CFG_LOCK_I
		 && !st_r.load_pend && !OTP_RELOAD_I) |=> $stable(st_r.sel) && $stable(st_r.sd))
		else $error("test config changed while locked");
	chk_sel_write: assert property (
		(REG_WR_I && REG_ADDR_I == vmon_cfg_pkg::ADDR_TEST_CFG && !CFG_LOCK_I
		 && !st_r.load_pend && !OTP_RELOAD_I) |=> st_r.sel == $past(REG_WDATA_I[1:0]))
		else $error("power-on field not written");
	chk_otp_load: assert property (
		OTP_RELOAD_I |=> st_r.sel == $past(OTP_SELTEST_SEL_I) && st_r.irq_enable_protect_group == $past(OTP_IEN_I))
		else $error("otp load missed");
	chk_sd_zero: assert property ((st_r.load_pend || OTP_RELOAD_I) |=> !st_r.sd)
		else $error("shutdown bit not cleared by load");
	chk_ien_lock: assert property (
		(REG_WR_I && IRQ_ENABLE_PROTECT_GROUP_I && !st_r.load_pend && !OTP_RELOAD_I)
		|=> $stable(st_r.irq_enable_protect_group))
		else $error("enable changed while locked");
	chk_rsvd_zero: assert property (
		$past(REG_RD_I) |-> REG_RDATA_O[7:6] == 2'h0)
		else $error("reserved bits not zero");
	chk_irq_follow: assert property (
		1'b1 |=> INTERRUPT_OUT_N_O == !($past(FORCE_INTERRUPT_OUT_I) || $past(|ch_hit)))
		else $error("interrupt pin wrong");
	chk_force_low: assert property (FORCE_INTERRUPT_OUT_I |=> !INTERRUPT_OUT_N_O)
		else $error("forced interrupt not low");
	chk_sd_start: assert property (
		(st_r.seq == vmon_cfg_pkg::ST_IDLE && !st_r.load_pend && st_r.act_d && !act_s && st_r.sd)
		|=> SELFTEST_RUN_O && !READY_O)
		else $error("deactivate self-test not started");
	chk_ready_wait: assert property (
		$rose(st_r.seq == vmon_cfg_pkg::ST_WAIT) |-> !READY_O [*1] ##WAIT_CYC READY_O)
		else $error("ready not after wait time");

	// self-test sequencing: start pulse shape and ready handling
	chk_run_pulse: assert property (SELFTEST_RUN_O |=> !SELFTEST_RUN_O)
		else $error("start pulse longer than one cycle");

	// ready is never claimed on the cycle a self-test starts
	chk_ready_drop: assert property (SELFTEST_RUN_O |-> !READY_O)
		else $error("ready high while self-test starts");

	// ready stays low for the whole wait
	chk_ready_low_wait: assert property (
		(st_r.seq == vmon_cfg_pkg::ST_WAIT) |-> !READY_O)
		else $error("ready high during wait");

	// the wait counter always starts from the full wait time
	chk_cnt_load: assert property (
		$rose(st_r.seq == vmon_cfg_pkg::ST_WAIT) |-> st_r.cnt == WAIT_LAST)
		else $error("wait counter not loaded");

	// the last wait cycle hands back to idle with ready high
	chk_seq_return: assert property (
		(st_r.seq == vmon_cfg_pkg::ST_WAIT && st_r.cnt == '0)
		|=> st_r.seq == vmon_cfg_pkg::ST_IDLE && READY_O)
		else $error("wait did not end in ready");

	// a deactivation edge while waiting must not start a second run
	chk_wait_no_start: assert property (
		(st_r.seq == vmon_cfg_pkg::ST_WAIT && st_r.cnt != '0) |=> !SELFTEST_RUN_O)
		else $error("self-test restarted during wait");

	// with the shutdown bit clear, a deactivation edge starts nothing
	chk_no_sd_start: assert property (
		(st_r.seq == vmon_cfg_pkg::ST_IDLE && !st_r.load_pend && st_r.act_d && !act_s
		 && !st_r.sd) |=> !SELFTEST_RUN_O)
		else $error("self-test started with shutdown bit clear");

	// power-on decode: only code 00 skips the run
	chk_por_run: assert property (
		(st_r.load_pend && st_r.seq == vmon_cfg_pkg::ST_IDLE)
		|=> SELFTEST_RUN_O == ($past(OTP_SELTEST_SEL_I) != 2'h0))
		else $error("power-on run decode wrong");

	// codes 01 and 10 mark the configuration as corrupt
	chk_por_corrupt: assert property (
		(st_r.load_pend && st_r.seq == vmon_cfg_pkg::ST_IDLE)
		|=> SELFTEST_CORRUPT_O == ($past(OTP_SELTEST_SEL_I) inside {2'h1, 2'h2}))
		else $error("power-on corrupt decode wrong");

	// otp load: the power-on field and every enable group come from otp
	chk_sel_load: assert property (
		st_r.load_pend |=> st_r.sel == $past(OTP_SELTEST_SEL_I))
		else $error("power-on field not loaded");
	chk_ien_load: assert property (
		st_r.load_pend |=> st_r.irq_enable_protect_group == $past(OTP_IEN_I))
		else $error("enables not loaded");

	// host write of the shutdown bit when the group is open
	chk_sd_write: assert property (
		(REG_WR_I && REG_ADDR_I == vmon_cfg_pkg::ADDR_TEST_CFG && !CFG_LOCK_I
		 && !st_r.load_pend && !OTP_RELOAD_I)
		|=> st_r.sd == $past(REG_WDATA_I[vmon_cfg_pkg::SD_BIT]))
		else $error("shutdown bit not written");

	// reads of the test config register show zero in the reserved bits
	chk_cfg_rsvd: assert property (
		$past(REG_RD_I && REG_ADDR_I == vmon_cfg_pkg::ADDR_TEST_CFG)
		|-> REG_RDATA_O[7:3] == 5'h00)
		else $error("config reserved bits not zero");

	// unmapped offsets read as zero rather than aliasing a register
	chk_rd_unmapped: assert property (
		(REG_RD_I && (REG_ADDR_I < vmon_cfg_pkg::ADDR_TEST_CFG
		 || REG_ADDR_I > vmon_cfg_pkg::ADDR_IEN_SOFF))
		|=> REG_RDATA_O == vmon_cfg_pkg::ZERO_BYTE)
		else $error("unmapped read not zero");

	// per group: a write lands in exactly the addressed enable register
	for (genvar g = 0; g < NIEN; g++)
	begin : g_ien_chk
		chk_ien_write: assert property (
			(REG_WR_I && REG_ADDR_I == vmon_cfg_pkg::ADDR_IEN_FUV + 8'(g)
			 && !IRQ_ENABLE_PROTECT_GROUP_I && !st_r.load_pend && !OTP_RELOAD_I)
			|=> st_r.irq_enable_protect_group[g] == $past(REG_WDATA_I[NCH-1:0]))
			else $error("enable write lost");
	end

	// per group and channel: an enabled flag must pull the pin low
	for (genvar g = 0; g < NIEN; g++)
	begin : g_gate_chk
		for (genvar c = 0; c < NCH; c++)
		begin : g_ch_chk
			chk_grp_gate: assert property (
				(flags[g][c] && st_r.irq_enable_protect_group[g][c]) |=> !INTERRUPT_OUT_N_O)
				else $error("enabled fault did not pull interrupt low");
		end
	end

	// the pin lets go once no enabled flag remains and force is off
	chk_irq_release: assert property (
		(!FORCE_INTERRUPT_OUT_I && !(|ch_hit)) |=> INTERRUPT_OUT_N_O)
		else $error("interrupt not released");

	cov_por_run:   cover property (SELFTEST_RUN_O && SELFTEST_CORRUPT_O);
	cov_sd_run:    cover property (st_r.sd ##1 SELFTEST_RUN_O);
	cov_irq:       cover property ($fell(INTERRUPT_OUT_N_O));
	cov_lock_wr:   cover property (REG_WR_I && IRQ_ENABLE_PROTECT_GROUP_I);
	cov_ready:     cover property ($rose(READY_O));
endmodule // selftest_irq_bank

// ===== hdl/vmon_cfg_pkg.sv
// constants and state types for the self-test and fault interrupt enable bank
package vmon_cfg_pkg;
	localparam int         NUM_CH        = 6;
	localparam int         NUM_IEN       = 6;
	localparam int         DATA_W        = 8;
	localparam int         ADDR_W        = 8;
	localparam int         CNT_W         = 16;
	localparam int         CLK_MHZ       = 100;
	localparam int         CFG_WAIT_NS   = 1000;
	// register offsets
	localparam logic [7:0] ADDR_TEST_CFG = 8'h12;
	localparam logic [7:0] ADDR_IEN_FUV  = 8'h13;
	localparam logic [7:0] ADDR_IEN_SUV  = 8'h14;
	localparam logic [7:0] ADDR_IEN_FOV  = 8'h15;
	localparam logic [7:0] ADDR_IEN_SOV  = 8'h16;
	localparam logic [7:0] ADDR_IEN_SON  = 8'h17;
	localparam logic [7:0] ADDR_IEN_SOFF = 8'h18;
	// enable group indices, in offset order
	localparam int         GRP_FUV       = 0;
	localparam int         GRP_SUV       = 1;
	localparam int         GRP_FOV       = 2;
	localparam int         GRP_SOV       = 3;
	localparam int         GRP_SON       = 4;
	localparam int         GRP_SOFF      = 5;
	// selftest_trigger_config fields
	localparam int         SEL_LSB       = 0;
	localparam int         SEL_MSB       = 1;
	localparam int         SD_BIT        = 2;
	localparam logic [1:0] SEL_SKIP      = 2'h0;
	localparam logic [1:0] SEL_RUN_VALID = 2'h3;
	localparam logic       SD_DEFAULT    = 1'h0;
	localparam logic [7:0] ZERO_BYTE     = 8'h00;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_WAIT
	} seq_t;

	typedef struct packed {
		logic [1:0]                        sel;
		logic                              sd;
		logic [NUM_IEN-1:0][NUM_CH-1:0]    irq_enable_protect_group;
		logic [DATA_W-1:0]                 rdata;
		logic                              irq_n;
		logic                              load_pend;
		logic [CNT_W-1:0]                  cnt;
		seq_t                              seq;
		logic                              act_d;
		logic                              run;
		logic                              corrupt;
		logic                              ready;
	} bank_t;
endpackage
